// [core/conv_status_ctl.sv]
// converter status flags, first control register and routine sequencer
// assumes an avalon-mm master on sys_clk and a converter core on the same clock
// Operation
// [RL1] software accesses the flags register only by full 32-bit words
// [RL2] conversion start flag sets at sequence start, cleared only by writing 0
// [RL3] end flag sets when a routine sequence conversion completes
// [RL4] end flag clears on write of 0 or on a result data read
// [RL5] threshold event flag sets on out-of-window result, cleared by writing 0
// [RL6] discontinuous group holds group count field plus one channels per trigger
// [RL7] bit 11 turns discontinuous operation on or off
// [RL8] bit 8 turns scanning of the configured sequence on or off
// [RL9] bit 23 enables threshold comparison; off means no threshold events
// [RL10] bit 9 limits monitoring to one selected channel, else all channels
// [RL11] five-bit field selects monitored channel 0 to 18 by binary value
// [RL12] software never programs monitored channel codes above 18
// [RL13] bit 6 gates the threshold event flag onto the interrupt
// [RL14] bit 5 gates the end flag onto the interrupt
// [RL15] channels 16, 17, 18 route to temperature, reference, half battery
// [RL16] software writes reserved bits as zero
// [RL17] each discontinuous trigger converts the next group until the sequence ends
// [RL18] thresholds compare the raw result before alignment
// [RL19] threshold interrupt raised while its flag and enable are both set
// [RL20] interrupt stays high while any flag meets its enable, drops when cleared
`timescale 1ns/1ps

module conv_status_ctl #(
  parameter int RESULT_W = conv_regs_pkg::RESULT_WIDTH,
  parameter int RANK_W   = conv_regs_pkg::RANK_WIDTH
) (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  // avalon-mm slave
  input  wire logic [3:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  // converter core
  input  wire logic                   trigger,
  input  wire logic                   conv_done,
  input  wire logic [RESULT_W-1:0]    conv_result,
  output logic                        conv_start,
  output logic      [4:0]             conv_channel,
  output conv_regs_pkg::source_t      source_sel,
  // sequence and threshold settings held elsewhere
  input  wire logic [RANK_W-1:0]      seq_last_rank,
  input  wire logic [4:0]             rank_channel,
  output logic      [RANK_W-1:0]      rank_index,
  input  wire logic [RESULT_W-1:0]    low_threshold,
  input  wire logic [RESULT_W-1:0]    high_threshold,
  // result data register read strobe
  input  wire logic                   data_read,
  // status
  output logic                        seq_busy,
  output logic                        irq
);

  // ****************************************
  // state
  // ****************************************
  logic [31:0]               control_reg;
  logic [31:0]               control_next;
  logic                      start_flag_reg;
  logic                      start_flag_next;
  logic                      end_flag_reg;
  logic                      end_flag_next;
  logic                      event_flag_reg;
  logic                      event_flag_next;
  logic                      wait_reg;
  logic                      wait_next;
  logic [31:0]               rdata_reg;
  logic [31:0]               rdata_next;
  logic                      irq_reg;
  logic                      irq_next;
  conv_regs_pkg::seq_state_t state_reg;
  conv_regs_pkg::seq_state_t state_next;
  logic [RANK_W-1:0]         rank_reg;
  logic [RANK_W-1:0]         rank_next;
  logic [2:0]                left_reg;
  logic [2:0]                left_next;
  logic                      start_reg;
  logic                      start_next;

  // ****************************************
  // control fields
  // ****************************************
  logic       scan_enable;
  logic       single_channel_monitor_select;
  logic       discontinuous_enable;
  logic       threshold_monitor_enable;
  logic       threshold_irq_enable;
  logic       conversion_end_irq_enable;
  logic [2:0] group_count_field;
  logic [4:0] monitored_channel_field;

  assign scan_enable                   = control_reg[conv_regs_pkg::SCAN_ENABLE_BIT]; // RL8
  assign single_channel_monitor_select = control_reg[conv_regs_pkg::SINGLE_CHANNEL_BIT];
  assign discontinuous_enable          = control_reg[conv_regs_pkg::DISCONT_ENABLE_BIT]; // RL7
  assign threshold_monitor_enable      = control_reg[conv_regs_pkg::THRESHOLD_MON_EN_BIT];
  assign threshold_irq_enable          = control_reg[conv_regs_pkg::THRESHOLD_IRQ_EN_BIT];
  assign conversion_end_irq_enable     = control_reg[conv_regs_pkg::CONV_END_IRQ_EN_BIT];
  assign group_count_field             = control_reg[conv_regs_pkg::GROUP_COUNT_LSB +:
                                                     conv_regs_pkg::GROUP_COUNT_WIDTH];
  assign monitored_channel_field       = control_reg[conv_regs_pkg::MON_CHANNEL_LSB +:
                                                     conv_regs_pkg::MON_CHANNEL_WIDTH]; // RL11

  // ****************************************
  // bus decode
  // ****************************************
  logic        bus_take;
  logic        wr_go;
  logic        wr_flags;
  logic        wr_control;
  logic [31:0] flags_view;
  logic [31:0] be_mask;

  always_comb begin
    bus_take   = (avs_read || avs_write) && wait_reg;
    wr_go      = avs_write && !wait_reg;
    wr_flags   = 1'b0;
    wr_control = 1'b0;
    if (wr_go && (avs_address == conv_regs_pkg::FLAGS_OFFSET)) begin
      // partial writes would clear flags they never meant to touch
      wr_flags = (avs_byteenable == conv_regs_pkg::FULL_WORD_ENABLES); // RL1
    end else if (wr_go && (avs_address == conv_regs_pkg::CONTROL_OFFSET)) begin
      wr_control = 1'b1;
    end
    be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    flags_view = conv_regs_pkg::FLAGS_RESET;
    flags_view[conv_regs_pkg::CONV_START_BIT]      = start_flag_reg;
    flags_view[conv_regs_pkg::CONV_END_BIT]        = end_flag_reg;
    flags_view[conv_regs_pkg::THRESHOLD_EVENT_BIT] = event_flag_reg;
  end

  // ****************************************
  // sequencer
  // ****************************************
  logic seq_begin;
  logic seq_finish;
  logic last_rank;

  always_comb begin
    state_next = state_reg;
    rank_next  = rank_reg;
    left_next  = left_reg;
    start_next = 1'b0;
    seq_begin  = 1'b0;
    seq_finish = 1'b0;
    last_rank  = (rank_reg == seq_last_rank) || !scan_enable;
    case (state_reg)
      conv_regs_pkg::SEQ_IDLE: begin
        if (trigger) begin
          state_next = conv_regs_pkg::SEQ_BUSY;
          start_next = 1'b1;
          seq_begin  = 1'b1;
          left_next  = group_count_field; // RL6
        end
      end
      conv_regs_pkg::SEQ_BUSY: begin
        if (conv_done) begin
          if (last_rank) begin
            seq_finish = 1'b1;
            rank_next  = '0;
            state_next = conv_regs_pkg::SEQ_IDLE;
          end else begin
            rank_next = rank_reg + 1'b1; // RL8
            if (discontinuous_enable && (left_reg == 3'h0)) begin
              // group done: wait for the next trigger, keep the rank
              state_next = conv_regs_pkg::SEQ_IDLE; // RL17
            end else begin
              start_next = 1'b1;
              left_next  = left_reg - 1'b1;
            end
          end
        end
      end
      default: begin
        state_next = conv_regs_pkg::SEQ_IDLE;
      end
    endcase
  end

  // ****************************************
  // threshold monitor and routing
  // ****************************************
  logic threshold_hit;

  threshold_monitor #(
    .WIDTH (RESULT_W)
  ) u_monitor (
    .sys_clk         (sys_clk),
    .rst_n           (rst_n),
    .valid           (conv_done && (state_reg == conv_regs_pkg::SEQ_BUSY)),
    .result          (conv_result),
    .channel         (conv_channel),
    .enable          (threshold_monitor_enable),
    .single          (single_channel_monitor_select),
    .watched_channel (monitored_channel_field),
    .low_limit       (low_threshold),
    .high_limit      (high_threshold),
    .event_pulse     (threshold_hit)
  );

  input_router u_router (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .start       (start_next),
    .channel     (rank_channel),
    .source_sel  (source_sel),
    .channel_out (conv_channel)
  );

  // ****************************************
  // registers, flags and bus answer
  // ****************************************
  always_comb begin
    control_next    = control_reg;
    start_flag_next = start_flag_reg;
    end_flag_next   = end_flag_reg;
    event_flag_next = event_flag_reg;
    wait_next       = 1'b1;
    rdata_next      = rdata_reg;
    if (wr_control) begin
      control_next = ((control_reg & ~be_mask) | (avs_writedata & be_mask))
                     & conv_regs_pkg::CONTROL_WRITE_MASK;
    end
    if (wr_flags) begin
      // writing 1 leaves a flag alone, writing 0 clears it
      start_flag_next = start_flag_reg & avs_writedata[conv_regs_pkg::CONV_START_BIT]; // RL2
      end_flag_next   = end_flag_reg & avs_writedata[conv_regs_pkg::CONV_END_BIT]; // RL4
      event_flag_next = event_flag_reg
                        & avs_writedata[conv_regs_pkg::THRESHOLD_EVENT_BIT]; // RL5
    end
    if (data_read) begin
      end_flag_next = 1'b0; // RL4
    end
    // hardware sets win over any clear in the same cycle
    if (seq_begin) begin
      start_flag_next = 1'b1; // RL2
    end
    if (seq_finish) begin
      end_flag_next = 1'b1; // RL3
    end
    if (threshold_hit) begin
      event_flag_next = 1'b1; // RL5
    end
    if (bus_take) begin
      wait_next = 1'b0;
      if (avs_address == conv_regs_pkg::FLAGS_OFFSET) begin
        rdata_next = flags_view;
      end else if (avs_address == conv_regs_pkg::CONTROL_OFFSET) begin
        rdata_next = control_reg;
      end else begin
        rdata_next = 32'h0000_0000;
      end
    end
    irq_next = (event_flag_next && threshold_irq_enable) // RL13 RL19
               || (end_flag_next && conversion_end_irq_enable); // RL14 RL20
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      control_reg    <= conv_regs_pkg::CONTROL_RESET;
      start_flag_reg <= 1'b0;
      end_flag_reg   <= 1'b0;
      event_flag_reg <= 1'b0;
      wait_reg       <= 1'b1;
      rdata_reg      <= 32'h0000_0000;
      irq_reg        <= 1'b0;
      state_reg      <= conv_regs_pkg::SEQ_IDLE;
      rank_reg       <= '0;
      left_reg       <= 3'h0;
      start_reg      <= 1'b0;
    end else begin
      control_reg    <= control_next;
      start_flag_reg <= start_flag_next;
      end_flag_reg   <= end_flag_next;
      event_flag_reg <= event_flag_next;
      wait_reg       <= wait_next;
      rdata_reg      <= rdata_next;
      irq_reg        <= irq_next;
      state_reg      <= state_next;
      rank_reg       <= rank_next;
      left_reg       <= left_next;
      start_reg      <= start_next;
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign conv_start      = start_reg;
  assign rank_index      = rank_reg;
  assign seq_busy        = (state_reg == conv_regs_pkg::SEQ_BUSY);
  assign irq             = irq_reg;

endmodule

// [common/conv_regs_pkg.sv]
// shared constants and types for the converter status and first control register block
// assumes a 32-bit avalon-mm register bus and a 12-bit conversion result
package conv_regs_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0]  FLAGS_OFFSET        = 4'h0;
  localparam logic [3:0]  CONTROL_OFFSET      = 4'h4;
  localparam logic [31:0] FLAGS_RESET         = 32'h0000_0000;
  localparam logic [31:0] CONTROL_RESET       = 32'h0000_0000;
  localparam logic [31:0] CONTROL_WRITE_MASK  = 32'h0080_eb7f;
  localparam logic [3:0]  FULL_WORD_ENABLES   = 4'hf;

  // ****************************************
  // flag bit positions
  // ****************************************
  localparam int THRESHOLD_EVENT_BIT  = 0;
  localparam int CONV_END_BIT         = 1;
  localparam int CONV_START_BIT       = 4;

  // ****************************************
  // control field positions
  // ****************************************
  localparam int MON_CHANNEL_LSB      = 0;
  localparam int MON_CHANNEL_WIDTH    = 5;
  localparam int CONV_END_IRQ_EN_BIT  = 5;
  localparam int THRESHOLD_IRQ_EN_BIT = 6;
  localparam int SCAN_ENABLE_BIT      = 8;
  localparam int SINGLE_CHANNEL_BIT   = 9;
  localparam int DISCONT_ENABLE_BIT   = 11;
  localparam int GROUP_COUNT_LSB      = 13;
  localparam int GROUP_COUNT_WIDTH    = 3;
  localparam int THRESHOLD_MON_EN_BIT = 23;

  // ****************************************
  // channel numbering
  // ****************************************
  localparam int          RESULT_WIDTH        = 12;
  localparam int          RANK_WIDTH          = 4;
  localparam logic [4:0]  TEMP_SENSOR_CHANNEL = 5'h10;
  localparam logic [4:0]  INTERNAL_REF_CHANNEL = 5'h11;
  localparam logic [4:0]  HALF_BATTERY_CHANNEL = 5'h12;

  typedef enum logic [1:0] {
    SRC_EXTERNAL_PIN  = 2'b00,
    SRC_TEMP_SENSOR   = 2'b01,
    SRC_INTERNAL_REF  = 2'b10,
    SRC_HALF_BATTERY  = 2'b11
  } source_t;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_BUSY = 1'b1
  } seq_state_t;

endpackage

// [core/input_router.sv]
// maps the channel about to be converted onto its analog source
// assumes channel and start come from logic on the same clock
`timescale 1ns/1ps

module input_router (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  // request
  input  wire logic                     start,
  input  wire logic [4:0]               channel,
  // routed selection
  output conv_regs_pkg::source_t        source_sel,
  output logic      [4:0]               channel_out
);

  function automatic conv_regs_pkg::source_t route_of(input logic [4:0] ch);
    if (ch == conv_regs_pkg::TEMP_SENSOR_CHANNEL) begin
      return conv_regs_pkg::SRC_TEMP_SENSOR;
    end else if (ch == conv_regs_pkg::INTERNAL_REF_CHANNEL) begin
      return conv_regs_pkg::SRC_INTERNAL_REF;
    end else if (ch == conv_regs_pkg::HALF_BATTERY_CHANNEL) begin
      return conv_regs_pkg::SRC_HALF_BATTERY;
    end else begin
      return conv_regs_pkg::SRC_EXTERNAL_PIN;
    end
  endfunction

  conv_regs_pkg::source_t source_reg;
  conv_regs_pkg::source_t source_next;
  logic [4:0]             channel_reg;
  logic [4:0]             channel_next;

  always_comb begin
    source_next  = source_reg;
    channel_next = channel_reg;
    if (start) begin
      source_next  = route_of(channel); // RL15
      channel_next = channel;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      source_reg  <= conv_regs_pkg::SRC_EXTERNAL_PIN;
      channel_reg <= 5'h00;
    end else begin
      source_reg  <= source_next;
      channel_reg <= channel_next;
    end
  end

  assign source_sel  = source_reg;
  assign channel_out = channel_reg;

endmodule

// [core/threshold_monitor.sv]
// compares each finished raw result against the low and high thresholds
// assumes result is the unaligned converter value, valid for one cycle
`timescale 1ns/1ps

module threshold_monitor #(
  parameter int WIDTH = conv_regs_pkg::RESULT_WIDTH
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // finished conversion
  input  wire logic             valid,
  input  wire logic [WIDTH-1:0] result,
  input  wire logic [4:0]       channel,
  // settings
  input  wire logic             enable,
  input  wire logic             single,
  input  wire logic [4:0]       watched_channel,
  input  wire logic [WIDTH-1:0] low_limit,
  input  wire logic [WIDTH-1:0] high_limit,
  // one-cycle event
  output logic                  event_pulse
);

  logic event_reg;
  logic event_next;
  logic in_scope;
  logic outside;

  always_comb begin
    in_scope   = !single || (channel == watched_channel); // RL10
    outside    = (result < low_limit) || (result > high_limit); // RL18
    event_next = valid && enable && in_scope && outside; // RL9
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      event_reg <= 1'b0;
    end else begin
      event_reg <= event_next;
    end
  end

  assign event_pulse = event_reg;

endmodule

// [sim/conv_status_ctl_assertions.sv]
// concurrent checks on the converter status and control block ports
// assumes it is bound to conv_status_ctl and sees its ports only
`timescale 1ns/1ps

module conv_status_ctl_assertions (
  // clock and reset
  input wire logic                    sys_clk,
  input wire logic                    rst_n,
  // register bus
  input wire logic [3:0]              avs_address,
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic [31:0]             avs_readdata,
  input wire logic                    avs_waitrequest,
  // converter side
  input wire logic                    trigger,
  input wire logic                    conv_done,
  input wire logic                    conv_start,
  input wire logic [4:0]              conv_channel,
  input wire conv_regs_pkg::source_t  source_sel,
  input wire logic [4:0]              rank_channel,
  input wire logic                    seq_busy
);
  logic [1:0] src_exp;

  // ****************************************
  // expected routing of internal channels
  // ****************************************
  assign src_exp = (conv_channel == 5'h10) ? 2'h1 : (conv_channel == 5'h11) ? 2'h2 :
                   (conv_channel == 5'h12) ? 2'h3 : 2'h0;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ****************************************
  // assertions
  // ****************************************
  bus_answer_a:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one cycle");
  answer_single_a:
    assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  unmapped_zero_a:
    assert property (avs_read && avs_waitrequest && avs_address != 4'h0 && avs_address != 4'h4
                     |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  reserved_zero_a:
    assert property (!avs_waitrequest |-> (avs_readdata & ~conv_regs_pkg::CONTROL_WRITE_MASK) == 0)
    else $error("reserved bits read nonzero");
  start_answer_a:
    assert property (trigger && !seq_busy |=> conv_start && seq_busy
                     && conv_channel == $past(rank_channel))
    else $error("trigger did not start conversion of the current rank");
  start_single_a:
    assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  busy_refuse_a:
    assert property (seq_busy && trigger && !conv_done |=> !conv_start)
    else $error("trigger taken while busy");
  idle_quiet_a:
    assert property (!seq_busy && !trigger |=> !conv_start)
    else $error("conversion started without trigger");
  source_map_a:
    assert property (conv_start |-> source_sel == src_exp)
    else $error("wrong analog source for channel");
endmodule

// [sim/conv_status_ctl_tb.sv]
// self-checking bench for the converter status and control block
// assumes the checker file is compiled before this top module
`timescale 1ns/1ps

module conv_status_ctl_tb;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        trigger = 1'b0;
  logic        conv_done = 1'b0;
  logic [11:0] conv_result = 12'h000;
  logic        conv_start;
  logic [4:0]  conv_channel;
  conv_regs_pkg::source_t source_sel;
  logic [3:0]  seq_last_rank = 4'h0;
  logic [4:0]  rank_channel;
  logic [3:0]  rank_index;
  logic [11:0] low_threshold = 12'h100;
  logic [11:0] high_threshold = 12'h200;
  logic        data_read = 1'b0;
  logic        seq_busy;
  logic        irq;
  int          num_errors = 0;
  int          n_compared = 0;
  int          starts = 0;

  always #2.5 sys_clk = ~sys_clk;
  // ranks 1..3 land on the internal channels so routing gets exercised
  assign rank_channel = 5'h0f + {1'b0, rank_index};
  always @(posedge sys_clk) if (conv_start === 1'b1) starts++;

  conv_status_ctl i_dut (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .trigger,
    .conv_done, .conv_result, .conv_start, .conv_channel, .source_sel, .seq_last_rank,
    .rank_channel, .rank_index, .low_threshold, .high_threshold, .data_read,
    .seq_busy, .irq);

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (k >= 20) begin
      num_errors++;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, 4'hf, q);
  endtask

  // trigger held three cycles so the later edges hit a busy sequencer
  task automatic convert(input int n, input logic [11:0] res);
    int s0;
    int k;
    s0 = starts;
    @(posedge sys_clk);
    trigger <= 1'b1;
    repeat (3) @(posedge sys_clk);
    trigger <= 1'b0;
    for (int i = 0; i < n; i++) begin
      k = 0;
      while (starts <= s0 + i && k < 50) begin
        @(negedge sys_clk);
        k++;
      end
      @(posedge sys_clk);
      conv_done <= 1'b1;
      conv_result <= res;
      @(posedge sys_clk);
      conv_done <= 1'b0;
    end
    repeat (6) @(negedge sys_clk);
    check(starts - s0, n);
    check(seq_busy, 1'b0);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic regs_scn();
    logic [31:0] q;
    rd(4'h0, q); check(q, 32'h0000_0000);
    rd(4'h4, q); check(q, 32'h0000_0000);
    wr(4'h4, 32'hffff_ffff);
    rd(4'h4, q); check(q, 32'h0080_eb7f);
    wr(4'h4, 32'h0000_0000, 4'h1);
    rd(4'h4, q); check(q, 32'h0080_eb00);
    wr(4'h8, 32'hffff_ffff);
    rd(4'h8, q); check(q, 32'h0000_0000);
    wr(4'h4, 32'h0000_0000);
  endtask

  task automatic single_scn();
    logic [31:0] q;
    wr(4'h4, 32'h0000_0020);
    convert(1, 12'h000);
    rd(4'h0, q); check(q, 32'h0000_0012);
    check(irq, 1'b1);
    wr(4'h0, 32'h0000_0000, 4'h1);
    rd(4'h0, q); check(q, 32'h0000_0012);
    @(posedge sys_clk);
    data_read <= 1'b1;
    @(posedge sys_clk);
    data_read <= 1'b0;
    rd(4'h0, q); check(q, 32'h0000_0010);
    check(irq, 1'b0);
    wr(4'h0, 32'h0000_0013);
    rd(4'h0, q); check(q, 32'h0000_0010);
    wr(4'h0, 32'h0000_0000);
    rd(4'h0, q); check(q, 32'h0000_0000);
  endtask

  task automatic seq_scn();
    logic [31:0] q;
    seq_last_rank <= 4'h3;
    wr(4'h4, 32'h0000_0100);
    convert(4, 12'h000);
    rd(4'h0, q); check(q, 32'h0000_0012);
    wr(4'h0, 32'h0000_0000);
    wr(4'h4, 32'h0000_2900);
    convert(2, 12'h000);
    rd(4'h0, q); check(q, 32'h0000_0010);
    convert(2, 12'h000);
    rd(4'h0, q); check(q, 32'h0000_0012);
    wr(4'h0, 32'h0000_0000);
    seq_last_rank <= 4'h0;
  endtask

  // rank 0 converts channel 15, so the single-channel cases pivot on that code
  task automatic thr_case(input logic [31:0] ctl, input logic [11:0] res,
                          input logic [31:0] exp);
    logic [31:0] q;
    wr(4'h4, ctl);
    convert(1, res);
    rd(4'h0, q); check(q, exp);
    // the event only reaches the interrupt while its enable is set
    check(irq, exp[0] & ctl[conv_regs_pkg::THRESHOLD_IRQ_EN_BIT]);
    wr(4'h0, 32'h0000_0012);
    repeat (2) @(negedge sys_clk);
    check(irq, 1'b0);
    wr(4'h0, 32'h0000_0000);
  endtask

  task automatic thr_scn();
    thr_case(32'h0080_0040, 12'h300, 32'h0000_0013);
    thr_case(32'h0080_0040, 12'h180, 32'h0000_0012);
    thr_case(32'h0080_0040, 12'h050, 32'h0000_0013);
    thr_case(32'h0000_0040, 12'h300, 32'h0000_0012);
    thr_case(32'h0080_0000, 12'h300, 32'h0000_0013);
    thr_case(32'h0080_0245, 12'h300, 32'h0000_0012);
    thr_case(32'h0080_024f, 12'h300, 32'h0000_0013);
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    regs_scn();
    single_scn();
    seq_scn();
    thr_scn();
    conclude();
  end

  initial begin
    #100000;
    num_errors++;
    conclude();
  end
endmodule

bind conv_status_ctl conv_status_ctl_assertions i_chk (.sys_clk, .rst_n, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .trigger, .conv_done,
  .conv_start, .conv_channel, .source_sel, .rank_channel, .seq_busy);
